/* design/pfa_defs.svh */
// Purpose: register map, field positions and reset values of the packet filter block
// Assumes: register indices are word indices; byte address is four times the index
// Notes: definitions only
`ifndef PFA_DEFS_SVH
`define PFA_DEFS_SVH

// register word indices
`define PFA_IDX_PKT_CFG 6'h37
`define PFA_IDX_PAY_LEN 6'h38
`define PFA_IDX_NODE 6'h39
`define PFA_IDX_BCAST 6'h3A
`define PFA_IDX_AUTO 6'h3B
`define PFA_IDX_OPMODE 6'h3C
`define PFA_IDX_STATUS 6'h3D

// packet config fields
`define PFA_CFG_FMT 7
`define PFA_CFG_KEEP 3
`define PFA_CFG_FILT_HI 2
`define PFA_CFG_FILT_LO 1

// auto mode fields
`define PFA_AUTO_ENT_HI 7
`define PFA_AUTO_ENT_LO 5
`define PFA_AUTO_EXT_HI 4
`define PFA_AUTO_EXT_LO 2
`define PFA_AUTO_MID_HI 1
`define PFA_AUTO_MID_LO 0

// reset values
`define PFA_RST_PKT_CFG 8'h00
`define PFA_RST_PAY_LEN 8'h40
`define PFA_RST_NODE 8'h00
`define PFA_RST_BCAST 8'h00
`define PFA_RST_AUTO 8'h00
`define PFA_RST_OPMODE 2'h1

`endif

/* design/pfa_pkg.sv */
// Purpose: types shared by the packet filter block
// Assumes: nothing beyond the defs header
// Notes: event codes follow the auto mode field encoding
package pfa_pkg;

  // filter selection codes
  typedef enum logic [1:0] {
    PFA_FILT_OFF = 2'b00,
    PFA_FILT_NODE = 2'b01,
    PFA_FILT_BOTH = 2'b10,
    PFA_FILT_RSVD = 2'b11
  } pfa_filt_e;

  // interrupt flags from the packet handler, all on ref_clk
  typedef struct packed {
    logic buffer_has_data_flag;
    logic fifo_level;
    logic crc_ok;
    logic payload_ready;
    logic sync_addr;
    logic packet_sent;
    logic timeout;
  } pfa_flags_s;

  // receive side strobes from the packet handler
  typedef struct packed {
    logic addr_valid;
    logic [7:0] addr;
    logic len_valid;
    logic [7:0] len;
    logic crc_done;
    logic crc_pass;
  } pfa_rx_s;

  // decisions back to the packet handler
  typedef struct packed {
    logic addr_accept;
    logic addr_reject;
    logic len_accept;
    logic len_reject;
    logic payload_done_irq;
    logic fifo_flush;
    logic rx_restart;
  } pfa_dec_s;

  // whole block state
  typedef struct packed {
    logic [7:0] pkt_cfg;
    logic [7:0] payload_len;
    logic [7:0] own_station_addr;
    logic [7:0] all_stations_addr;
    logic [7:0] auto_ctl;
    logic [1:0] op_mode;
    logic seq_active;
    pfa_flags_s flags_prev;
    pfa_dec_s dec;
    logic ack;
    logic [31:0] rdata;
  } pfa_state_s;

endpackage

/* design/pfa_top.sv */
// Purpose: address/length filter, crc fail handling and auto mode sequencer
// Assumes: packet handler strobes and flags are on ref_clk
// Notes: Avalon-MM slave, one wait state per access
//   word map: 0x37 packet config, 0x38 payload length, 0x39 node address,
//   0x3A broadcast address, 0x3B auto modes, 0x3C resting mode, 0x3D status
//   packet config: bit 7 variable format, bit 3 keep fifo on crc fail,
//   bits 2:1 address filter selection
//   auto modes: bits 7:5 entry event, 4:2 exit event, 1:0 interim mode
//   writes land at the edge that completes the access, one cycle after the wait state ends,
//   so an abandoned write leaves every register untouched
//   read data is registered in the first cycle and stands until the next read
//   every decision toward the packet handler is a registered one-cycle pulse
//   flags are sampled once per cycle; a pulse shorter than a cycle is lost
// Function
// - keep fifo, raise payload irq on crc fail
// - otherwise flush fifo, restart, no irq
// - filter code 00 accepts every address
// - code 01 accepts node address only
// - code 10 accepts node or broadcast
// - fixed format uses exact payload length
// - variable format: max rx length, tx ignores
// - node address register, reset zero
// - broadcast address register, reset zero
// - enter event field, 000 off, 001 fifo-not-empty
// - exit event field, 000 off, 001 fifo empty
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "pfa_defs.svh"

// equality match of a received address against one programmed address
module pfa_addr_match #(
  parameter int W = 8
) (
  // address seen in the packet and the programmed one
  input wire logic [W-1:0] seen,
  input wire logic [W-1:0] want,
  // result
  output logic hit
);

  // a zero width would match everything
  if (W < 1) begin : g_chk
    $error("W must be at least one");
  end

  // plain compare; the caller decides which matches count
  assign hit = (seen == want);

endmodule

// rising and falling edges of a set of level flags
module pfa_edge #(
  parameter int W = 1
) (
  // level now and one cycle ago
  input wire logic [W-1:0] cur_lvl,
  input wire logic [W-1:0] old_lvl,
  // edges, valid in the cycle in which the new level first shows
  output logic [W-1:0] up,
  output logic [W-1:0] down
);

  // a zero width leaves nothing to watch
  if (W < 1) begin : g_chk
    $error("W must be at least one");
  end

  // both views from the same two samples, so an edge is never seen twice
  assign up = cur_lvl & ~old_lvl;
  assign down = ~cur_lvl & old_lvl;

endmodule

module pfa_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // avalon-mm slave, word addressed
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // packet handler side
  input wire pfa_pkg::pfa_rx_s rx_in,
  input wire pfa_pkg::pfa_flags_s irq_flags,
  output pfa_pkg::pfa_dec_s rx_dec,
  // transmit length and operating mode
  output logic [7:0] tx_len,
  output logic tx_len_fixed,
  output logic [1:0] cur_mode
);

  // word index must reach the highest register
  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  // an index wider than the data word makes no sense on this bus
  if (ADDR_W > 32) begin : g_chk_hi
    $error("ADDR_W wider than the data word");
  end

  pfa_pkg::pfa_state_s st_r;
  pfa_pkg::pfa_state_s st_nxt;
  pfa_pkg::pfa_filt_e filt;
  logic keep_fifo;
  logic fmt_var;
  logic [2:0] ent_code;
  logic [2:0] ext_code;
  logic [1:0] mid_mode;
  logic [ADDR_W-1:0] idx;
  logic req;
  logic [7:0] wbyte;
  logic [7:0] status;
  pfa_pkg::pfa_flags_s rise;
  pfa_pkg::pfa_flags_s fall;
  logic ent_hit;
  logic ext_hit;
  logic seq_on;
  logic wr_go;
  logic rd_go;
  logic sel_cfg;
  logic sel_len;
  logic sel_node;
  logic sel_bcast;
  logic sel_auto;
  logic sel_mode;
  logic sel_stat;
  logic node_hit;
  logic bcast_hit;

  // field views of the config registers
  assign filt = pfa_pkg::pfa_filt_e'(st_r.pkt_cfg[`PFA_CFG_FILT_HI:`PFA_CFG_FILT_LO]);
  assign keep_fifo = st_r.pkt_cfg[`PFA_CFG_KEEP];
  assign fmt_var = st_r.pkt_cfg[`PFA_CFG_FMT];
  assign ent_code = st_r.auto_ctl[`PFA_AUTO_ENT_HI:`PFA_AUTO_ENT_LO];
  assign ext_code = st_r.auto_ctl[`PFA_AUTO_EXT_HI:`PFA_AUTO_EXT_LO];
  assign mid_mode = st_r.auto_ctl[`PFA_AUTO_MID_HI:`PFA_AUTO_MID_LO];
  assign idx = avs_address;
  assign req = avs_read | avs_write;
  assign wbyte = avs_writedata[7:0];
  assign status = {5'h00, st_r.seq_active, cur_mode};

  // bus strobes; read data is fetched in the wait cycle, a write lands as the access completes, one cycle after the wait ends
  assign wr_go = avs_write & st_r.ack;
  assign rd_go = avs_read & ~st_r.ack;

  // register selects
  assign sel_cfg = (idx == ADDR_W'(`PFA_IDX_PKT_CFG));
  assign sel_len = (idx == ADDR_W'(`PFA_IDX_PAY_LEN));
  assign sel_node = (idx == ADDR_W'(`PFA_IDX_NODE));
  assign sel_bcast = (idx == ADDR_W'(`PFA_IDX_BCAST));
  assign sel_auto = (idx == ADDR_W'(`PFA_IDX_AUTO));
  assign sel_mode = (idx == ADDR_W'(`PFA_IDX_OPMODE));
  assign sel_stat = (idx == ADDR_W'(`PFA_IDX_STATUS));

  // sequencer runs only while both events are chosen; either at 000 stops it
  assign seq_on = (ent_code != 3'h0) & (ext_code != 3'h0);

  // flag edges; flags come from same-clock logic, so no synchroniser
  pfa_edge #(
    .W($bits(pfa_pkg::pfa_flags_s))
  ) u_flag_edge (
    .cur_lvl(irq_flags),
    .old_lvl(st_r.flags_prev),
    .up(rise),
    .down(fall)
  );

  // one comparator per programmed address
  pfa_addr_match #(
    .W($bits(rx_in.addr))
  ) u_node_match (
    .seen(rx_in.addr),
    .want(st_r.own_station_addr),
    .hit(node_hit)
  );
  pfa_addr_match #(
    .W($bits(rx_in.addr))
  ) u_bcast_match (
    .seen(rx_in.addr),
    .want(st_r.all_stations_addr),
    .hit(bcast_hit)
  );

  // enter event decode
  // codes 2 to 6 follow rising edges of the other flags, all but timeout
  always_comb begin
    unique case (ent_code)
      3'h0: ent_hit = 1'b0;
      3'h1: ent_hit = rise.buffer_has_data_flag;
      3'h2: ent_hit = rise.fifo_level;
      3'h3: ent_hit = rise.crc_ok;
      3'h4: ent_hit = rise.payload_ready;
      3'h5: ent_hit = rise.sync_addr;
      3'h6: ent_hit = rise.packet_sent;
      3'h7: ent_hit = fall.buffer_has_data_flag;
    endcase
  end

  // exit event decode; most exits also leave on timeout
  always_comb begin
    unique case (ext_code)
      3'h0: ext_hit = 1'b0;
      3'h1: ext_hit = fall.buffer_has_data_flag;
      3'h2: ext_hit = rise.fifo_level | rise.timeout;
      3'h3: ext_hit = rise.crc_ok | rise.timeout;
      3'h4: ext_hit = rise.payload_ready | rise.timeout;
      3'h5: ext_hit = rise.sync_addr | rise.timeout;
      3'h6: ext_hit = rise.packet_sent;
      3'h7: ext_hit = rise.timeout;
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.flags_prev = irq_flags;
    st_nxt.dec = '0;

    // bus: first cycle of a request waits, second completes
    st_nxt.ack = req & ~st_r.ack;
    // byte lane 0 carries every register; the other lanes are ignored
    if (wr_go & avs_byteenable[0]) begin
      if (sel_cfg) begin
        st_nxt.pkt_cfg = wbyte;
      end
      if (sel_len) begin
        st_nxt.payload_len = wbyte;
      end
      if (sel_node) begin
        st_nxt.own_station_addr = wbyte;
      end
      if (sel_bcast) begin
        st_nxt.all_stations_addr = wbyte;
      end
      if (sel_auto) begin
        st_nxt.auto_ctl = wbyte;
      end
      if (sel_mode) begin
        st_nxt.op_mode = wbyte[1:0];
      end
    end
    // status is read only; a write to it is dropped
    if (rd_go) begin
      st_nxt.rdata = 32'h00000000; // unmapped reads return zero
      if (sel_cfg) begin
        st_nxt.rdata[7:0] = st_r.pkt_cfg;
      end
      if (sel_len) begin
        st_nxt.rdata[7:0] = st_r.payload_len;
      end
      if (sel_node) begin
        st_nxt.rdata[7:0] = st_r.own_station_addr;
      end
      if (sel_bcast) begin
        st_nxt.rdata[7:0] = st_r.all_stations_addr;
      end
      if (sel_auto) begin
        st_nxt.rdata[7:0] = st_r.auto_ctl;
      end
      if (sel_mode) begin
        st_nxt.rdata[1:0] = st_r.op_mode;
      end
      if (sel_stat) begin
        st_nxt.rdata[7:0] = status;
      end
    end

    // address filter; reserved code behaves as off
    if (rx_in.addr_valid) begin
      unique case (filt)
        pfa_pkg::PFA_FILT_NODE: begin
          st_nxt.dec.addr_accept = node_hit;
        end
        pfa_pkg::PFA_FILT_BOTH: begin
          st_nxt.dec.addr_accept = node_hit | bcast_hit;
        end
        pfa_pkg::PFA_FILT_OFF, pfa_pkg::PFA_FILT_RSVD: begin
          st_nxt.dec.addr_accept = 1'b1;
        end
      endcase
      st_nxt.dec.addr_reject = ~st_nxt.dec.addr_accept;
    end

    // length check: exact when fixed, ceiling when variable
    // one register serves both directions; transmit reads it through tx_len
    if (rx_in.len_valid) begin
      if (fmt_var) begin
        st_nxt.dec.len_accept = (rx_in.len <= st_r.payload_len);
      end else begin
        st_nxt.dec.len_accept = (rx_in.len == st_r.payload_len);
      end
      st_nxt.dec.len_reject = ~st_nxt.dec.len_accept;
    end

    // crc verdict
    // a passing crc always raises the payload irq
    if (rx_in.crc_done) begin
      if (rx_in.crc_pass | keep_fifo) begin
        st_nxt.dec.payload_done_irq = 1'b1;
      end else begin
        st_nxt.dec.fifo_flush = 1'b1;
        st_nxt.dec.rx_restart = 1'b1;
      end
    end

    // sequencer; both fields must be nonzero to run
    // leaving on the entry edge itself needs the exit edge a cycle later
    if (!seq_on) begin
      st_nxt.seq_active = 1'b0;
    end else if (!st_r.seq_active & ent_hit) begin
      st_nxt.seq_active = 1'b1;
    end else if (st_r.seq_active & ext_hit) begin
      st_nxt.seq_active = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // configuration back to its reset values; no state survives a reset
      st_r <= '0;
      st_r.pkt_cfg <= `PFA_RST_PKT_CFG;
      st_r.payload_len <= `PFA_RST_PAY_LEN;
      st_r.own_station_addr <= `PFA_RST_NODE;
      st_r.all_stations_addr <= `PFA_RST_BCAST;
      st_r.auto_ctl <= `PFA_RST_AUTO;
      st_r.op_mode <= `PFA_RST_OPMODE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  // cur_mode falls back to the resting mode as soon as the sequencer stops
  assign avs_waitrequest = req & ~st_r.ack;
  assign avs_readdata = st_r.rdata;
  assign rx_dec = st_r.dec;
  assign tx_len = st_r.payload_len;
  assign tx_len_fixed = ~fmt_var;
  assign cur_mode = st_r.seq_active ? mid_mode : st_r.op_mode;

endmodule

/* bench/pfa_chk_sva.sv */
// Purpose: port checker for the packet filter block
// Assumes: one ref_clk domain, rst_b async low
// Notes: bound from the bench top
`timescale 1ns/100ps
module pfa_chk #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // packet handler side
  input wire pfa_pkg::pfa_rx_s rx_in,
  input wire pfa_pkg::pfa_flags_s irq_flags,
  input wire pfa_pkg::pfa_dec_s rx_dec,
  // length and mode
  input wire logic [7:0] tx_len,
  input wire logic tx_len_fixed,
  input wire logic [1:0] cur_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // verdicts come exactly one cycle after their strobe; an address verdict never comes without one
  property p_addr_one; rx_in.addr_valid |=> rx_dec.addr_accept ^ rx_dec.addr_reject; endproperty
  property p_addr_quiet; !rx_in.addr_valid |=> !(rx_dec.addr_accept | rx_dec.addr_reject); endproperty
  property p_len_one; rx_in.len_valid |=> rx_dec.len_accept ^ rx_dec.len_reject; endproperty
  // a failed crc either keeps the fifo with irq, or flushes and restarts without it
  property p_crc_fail;
    rx_in.crc_done && !rx_in.crc_pass |=> (rx_dec.fifo_flush == rx_dec.rx_restart) &&
      (rx_dec.fifo_flush ^ rx_dec.payload_done_irq);
  endproperty
  property p_irq_cause; rx_dec.payload_done_irq |-> $past(rx_in.crc_done); endproperty
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_tx_hold; !avs_write |=> $stable(tx_len) && $stable(tx_len_fixed); endproperty
  // mode moves only after a register write or a flag edge
  property p_mode_cause;
    $changed(cur_mode) |-> $past(avs_write) || ($past(irq_flags) != $past(irq_flags, 2));
  endproperty
  a_addr_one: assert property (p_addr_one) else $error("address verdict count wrong");
  a_addr_quiet: assert property (p_addr_quiet) else $error("address verdict without strobe");
  a_len_one: assert property (p_len_one) else $error("length verdict count wrong");
  a_crc_fail: assert property (p_crc_fail) else $error("crc fail handling wrong");
  a_irq_cause: assert property (p_irq_cause) else $error("payload irq without crc result");
  a_wait_one: assert property (p_wait_one) else $error("more than one wait state");
  a_tx_hold: assert property (p_tx_hold) else $error("tx length moved without write");
  a_mode_cause: assert property (p_mode_cause) else $error("mode moved without cause");
  c_accept: cover property (rx_dec.addr_accept);
  c_flush: cover property (rx_dec.fifo_flush);
  c_interim: cover property (cur_mode == 2'h3);
endmodule

/* bench/pfa_far.sv */
// Purpose: packet handler model feeding strobes and flags
// Assumes: driven from bench tasks, changes just after rising edges
// Notes: data lines show inverted data once the strobe is gone
`timescale 1ns/100ps
module pfa_far (
  // clock
  input wire logic ref_clk,
  // toward the block
  output pfa_pkg::pfa_rx_s rx_in,
  output pfa_pkg::pfa_flags_s irq_flags,
  // verdicts back
  input wire pfa_pkg::pfa_dec_s rx_dec
);
  initial begin
    rx_in = '0;
    irq_flags = '0;
  end
  // k: 0 address, 1 length, 2 crc; verdict taken once the strobe edge has landed
  task automatic strobe(input int k, input logic [7:0] v, input logic p, output pfa_pkg::pfa_dec_s d);
    @(posedge ref_clk);
    rx_in <= {k == 0, v, k == 1, v, k == 2, p};
    @(posedge ref_clk);
    rx_in <= {1'b0, ~v, 1'b0, ~v, 1'b0, ~p};
    #1 d = rx_dec;
  endtask
  // fifo holds data or not
  task automatic set_fill(input logic f);
    @(posedge ref_clk);
    irq_flags.buffer_has_data_flag <= f;
  endtask
endmodule

/* bench/tb_packet_filter_and_auto_modes.sv */
// Purpose: bench for filter, length, crc and auto mode logic
// Assumes: one wait state bus, verdicts one cycle after strobe
// Notes: no random stimulus
`timescale 1ns/100ps
module tb_packet_filter_and_auto_modes;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pfa_pkg::pfa_rx_s rx_in;
  pfa_pkg::pfa_flags_s irq_flags;
  pfa_pkg::pfa_dec_s rx_dec, d;
  logic [7:0] tx_len;
  logic tx_len_fixed;
  logic [1:0] cur_mode;
  logic [31:0] rd;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] ra [5] = '{8'h38, 8'h39, 8'h3A, 8'h3B, 8'h10};
  logic [7:0] rv [5] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ad [3] = '{8'h5A, 8'hA5, 8'h33};
  logic [2:0] acc [4] = '{3'b111, 3'b001, 3'b011, 3'b111};
  logic [2:0] la [2] = '{3'b010, 3'b011};
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  pfa_top u_dut (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .rx_in, .irq_flags, .rx_dec, .tx_len, .tx_len_fixed, .cur_mode);
  pfa_far u_far (.ref_clk, .rx_in, .irq_flags, .rx_dec);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (ra[i]) begin bus(0, ra[i], 0, rd); check(rd, rv[i]); end
    bus(1, 8'h39, 8'h5A, rd);
    bus(1, 8'h3A, 8'hA5, rd);
    bus(0, 8'h3A, 0, rd); check(rd, 32'hA5);
    // every filter code against node, broadcast and a stranger
    for (int c = 0; c < 4; c++) begin
      bus(1, 8'h37, {5'h00, c[1:0], 1'b0}, rd);
      for (int j = 0; j < 3; j++) begin
        u_far.strobe(0, ad[j], 1'b0, d);
        check(d.addr_accept, acc[c][j]);
      end
    end
    // lengths just below, at and above the setting, fixed then variable
    bus(1, 8'h38, 8'h10, rd);
    for (int f = 0; f < 2; f++) begin
      bus(1, 8'h37, {f[0], 7'h00}, rd);
      #1 check(tx_len_fixed, !f[0]);
      for (int j = 0; j < 3; j++) begin
        u_far.strobe(1, 8'(8'h0F + j), 1'b0, d);
        check(d.len_accept, la[f][j]);
      end
    end
    check(tx_len, 8'h10);
    // crc failure with and without keeping the fifo
    for (int k = 0; k < 2; k++) begin
      bus(1, 8'h37, {4'h0, k[0], 3'h0}, rd);
      u_far.strobe(2, 8'h00, 1'b0, d);
      check({d.payload_done_irq, d.fifo_flush, d.rx_restart}, k ? 3'b100 : 3'b011);
    end
    bus(1, 8'h3B, 8'h27, rd);
    u_far.set_fill(1'b1);
    repeat (2) @(posedge ref_clk);
    #1 check(cur_mode, 2'h3);
    bus(0, 8'h3D, 0, rd); check(rd, 32'h7);
    u_far.set_fill(1'b0);
    repeat (2) @(posedge ref_clk);
    #1 check(cur_mode, 2'h1);
    // both conditions off: a fill edge must not move the mode
    bus(1, 8'h3B, 8'h03, rd);
    u_far.set_fill(1'b1);
    repeat (3) @(posedge ref_clk);
    #1 check(cur_mode, 2'h1);
    // resting mode written directly shows on cur_mode and reads back
    bus(1, 8'h3C, 8'h02, rd);
    #1 check(cur_mode, 2'h2);
    bus(0, 8'h3C, 0, rd); check(rd, 32'h2);
    report_and_stop();
  end
endmodule
bind pfa_top pfa_chk #(.ADDR_W(ADDR_W)) u_chk (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_in, .irq_flags, .rx_dec, .tx_len,
  .tx_len_fixed, .cur_mode);
